// File: inc/srcp_defs.svh
/*
  Constants of the RS485 command parser: packet bytes, flag fields,
  memory-map layout, defaults and timing. Assumes a 10 MHz system clock.
*/
`ifndef SRCP_DEFS_SVH
`define SRCP_DEFS_SVH
`define SRCP_HDR0        8'hfa
`define SRCP_HDR1        8'haf
`define SRCP_RHDR0       8'hfd
`define SRCP_RHDR1       8'hdf
`define SRCP_ACK         8'h07
`define SRCP_BCAST       8'hff
`define SRCP_CMD_ADR     8'hff
`define SRCP_INIT_LEN    8'hff
`define SRCP_REPLY_CNT   8'h01
`define SRCP_FLG_COMMIT  8'h40
`define SRCP_FLG_REBOOT  8'h20
`define SRCP_FLG_INIT    8'h10
`define SRCP_ST_TLIM     7
`define SRCP_ST_TALM     5
`define SRCP_ST_FERR     3
`define SRCP_MAP_SIZE    60
`define SRCP_NV_LO       4
`define SRCP_ID_IDX      4
`define SRCP_BAUD_IDX    6
`define SRCP_DLY_IDX     7
`define SRCP_RO_LO       14
`define SRCP_RO_HI       15
`define SRCP_DEF_ID      8'h01
`define SRCP_DEFAULTS    208'h09c4_0000_0808_0000_0000_0000_0000_0055_0000_f63c_09c4_0007_0001
`define SRCP_BAUD_N      11
`define SRCP_BAUD_TABLE  '{9600, 14400, 19200, 28800, 38400, 57600, 76800, 115200, \
                           153600, 230400, 460800}
`define SRCP_CLK_HZ      10000000
`define SRCP_DLY_UNIT_US 1000
`define SRCP_MS_CYCLES   (`SRCP_CLK_HZ / 1000000 * `SRCP_DLY_UNIT_US)
`endif

// File: inc/srcp_pkg.sv
/*
  Types of the RS485 command parser.
  Assumes the constants header is compiled alongside.
*/
package srcp_pkg;
  typedef enum logic [3:0] {
    SRCP_IDLE  = 4'h0,
    SRCP_HDR2  = 4'h1,
    SRCP_ID    = 4'h2,
    SRCP_FLG   = 4'h3,
    SRCP_ADR   = 4'h4,
    SRCP_LEN   = 4'h5,
    SRCP_CNT   = 4'h6,
    SRCP_DAT   = 4'h7,
    SRCP_SUM   = 4'h8,
    SRCP_EXEC  = 4'h9,
    SRCP_DELAY = 4'ha,
    SRCP_TX    = 4'hb
  } srcp_st_type;
endpackage : srcp_pkg

// File: rtl/srcp_parser.sv
/*
  RS485 command parser: UART receive and transmit, packet checking,
  memory map with flash copy, commands and replies.
  Assumes an external RS485 transceiver and inputs synchronous to i_clock.
*/
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "srcp_defs.svh"
module srcp_parser #(
  parameter int         BUF       = 32,
  parameter int         MS_CYCLES = `SRCP_MS_CYCLES,
  parameter logic [7:0] MODEL_L   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] MODEL_H   = 8'ha5,  // Arbitrary value
  parameter logic [7:0] FW_VER    = 8'h01   // Arbitrary value
) (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_rx,
  input  wire logic [5:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_temp_limit,
  input  wire logic       i_temp_alarm,
  input  wire logic       i_flash_fail,
  output logic            o_tx,
  output logic            o_tx_en,
  output logic [7:0]      o_rdata,
  output logic            o_reboot,
  output logic            o_commit
);
  localparam int BAUD [`SRCP_BAUD_N] = `SRCP_BAUD_TABLE;
  localparam int NVN = 26;

  initial begin
    if (BUF < 1 || BUF > 255 || MS_CYCLES < 1 || MS_CYCLES > 65535) begin
      $error("srcp_parser: unsupported parameter value");
    end
  end

  typedef struct packed {
    srcp_pkg::srcp_st_type   st;
    logic [15:0]             rx_cnt;
    logic [3:0]              rx_bit;
    logic [7:0]              rx_sh;
    logic                    rx_busy;
    logic                    rx_vld;
    logic [7:0]              rx_byte;
    logic [7:0]              id;
    logic [7:0]              flg;
    logic [7:0]              adr;
    logic [7:0]              len;
    logic [7:0]              cnt;
    logic [7:0]              sum;
    logic [7:0]              pos;
    logic [7:0]              blk;
    logic [7:0]              nbuf;
    logic                    bm;
    logic                    match;
    logic                    long_pk;
    logic [BUF-1:0][7:0]     buf_q;
    logic [59:0][7:0]        mem;
    logic [NVN-1:0][7:0]     nvm;
    logic [15:0]             ms_cnt;
    logic [7:0]              ms_left;
    logic [15:0]             tx_cnt;
    logic [3:0]              tx_bit;
    logic [9:0]              tx_sh;
    logic                    tx_busy;
    logic [8:0]              tx_k;
    logic [7:0]              tx_sum;
    logic [7:0]              r_adr;
    logic [7:0]              r_len;
    logic                    ack;
    logic                    tx;
    logic                    tx_en;
    logic [7:0]              rdata;
    logic                    reboot;
    logic                    commit;
  } srcp_regs_type;

  srcp_regs_type s_reg;
  srcp_regs_type s_next;
  logic [15:0]   divs [`SRCP_BAUD_N];
  logic [15:0]   div;
  logic [7:0]    own_id;
  logic [7:0]    stat;
  logic [7:0]    cur_byte;
  logic [8:0]    tx_last;
  logic [8:0]    ridx;

  // Bit period per baud code
  for (genvar g = 0; g < `SRCP_BAUD_N; g++) begin : g_div
    assign divs[g] = 16'(`SRCP_CLK_HZ / BAUD[g]);
  end

  // Baud select, own identity and reply status
  always_comb begin
    div    = divs[7];
    if (s_reg.mem[`SRCP_BAUD_IDX] < 8'(`SRCP_BAUD_N)) begin
      div = divs[s_reg.mem[`SRCP_BAUD_IDX][3:0]];
    end
    own_id = s_reg.mem[`SRCP_ID_IDX];
    stat   = 8'h00;
    stat[`SRCP_ST_TLIM] = i_temp_limit;
    stat[`SRCP_ST_TALM] = i_temp_alarm;
    stat[`SRCP_ST_FERR] = i_flash_fail;
  end

  // Byte to send at reply position tx_k
  always_comb begin
    tx_last  = s_reg.ack ? 9'h000 : 9'(9'h007 + s_reg.r_len);
    ridx     = 9'(s_reg.r_adr + s_reg.tx_k - 9'h007);
    cur_byte = 8'h00;
    if (s_reg.ack) begin
      cur_byte = `SRCP_ACK;
    end else begin
      case (s_reg.tx_k)
        9'h000:  cur_byte = `SRCP_RHDR0;
        9'h001:  cur_byte = `SRCP_RHDR1;
        9'h002:  cur_byte = own_id;
        9'h003:  cur_byte = stat;
        9'h004:  cur_byte = s_reg.r_adr;
        9'h005:  cur_byte = s_reg.r_len;
        9'h006:  cur_byte = `SRCP_REPLY_CNT;
        default: begin
          if (s_reg.tx_k == tx_last) begin
            cur_byte = s_reg.tx_sum;
          end else if (ridx < 9'(`SRCP_MAP_SIZE)) begin
            cur_byte = s_reg.mem[ridx];
          end
        end
      endcase
    end
  end

  // Next state of the whole block
  always_comb begin
    logic [7:0] b;
    logic       addressed;
    logic       cmd;
    logic [7:0] off;
    b         = s_reg.rx_byte;
    addressed = 1'b0;
    cmd       = 1'b0;
    off       = 8'h00;
    s_next        = s_reg;
    s_next.rx_vld = 1'b0;
    s_next.reboot = 1'b0;
    s_next.commit = 1'b0;
    // UART receiver, 8N1, sampled mid-bit
    if (!s_reg.rx_busy) begin
      if (!i_rx) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_bit  = 4'h0;
        s_next.rx_cnt  = {1'b0, div[15:1]};
      end
    end else if (s_reg.rx_cnt != 16'h0000) begin
      s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
    end else begin
      s_next.rx_cnt = div - 16'h0001;
      s_next.rx_bit = s_reg.rx_bit + 4'h1;
      if (s_reg.rx_bit == 4'h0) begin
        s_next.rx_busy = ~i_rx;  // False start is dropped
      end else if (s_reg.rx_bit == 4'h9) begin
        s_next.rx_busy = 1'b0;
        s_next.rx_vld  = i_rx;  // Framing error drops the byte
        s_next.rx_byte = s_reg.rx_sh;
      end else begin
        s_next.rx_sh = {i_rx, s_reg.rx_sh[7:1]};
      end
    end
    // Register port writes, map entries 0-3 fixed
    if (i_wr && i_addr < 6'(`SRCP_MAP_SIZE) && i_addr >= 6'(`SRCP_NV_LO)
        && i_addr != 6'(`SRCP_RO_LO) && i_addr != 6'(`SRCP_RO_HI)) begin
      s_next.mem[i_addr] = i_wdata;
    end
    if (i_rd) begin
      s_next.rdata = (i_addr < 6'(`SRCP_MAP_SIZE)) ? s_reg.mem[i_addr] : 8'h00;
    end
    // Packet parser
    case (s_reg.st)
      srcp_pkg::SRCP_IDLE: begin
        if (s_reg.rx_vld && b == `SRCP_HDR0) begin
          s_next.st = srcp_pkg::SRCP_HDR2;
        end
      end
      srcp_pkg::SRCP_HDR2: begin
        if (s_reg.rx_vld) begin
          s_next.st = (b == `SRCP_HDR1) ? srcp_pkg::SRCP_ID :
                      (b == `SRCP_HDR0) ? srcp_pkg::SRCP_HDR2 : srcp_pkg::SRCP_IDLE;
        end
      end
      srcp_pkg::SRCP_ID: begin
        if (s_reg.rx_vld) begin
          s_next.id  = b;
          s_next.sum = b;
          s_next.st  = srcp_pkg::SRCP_FLG;
        end
      end
      srcp_pkg::SRCP_FLG, srcp_pkg::SRCP_ADR, srcp_pkg::SRCP_LEN: begin
        if (s_reg.rx_vld) begin
          s_next.sum = s_reg.sum ^ b;
          s_next.st  = srcp_pkg::srcp_st_type'(s_reg.st + 4'h1);
          if (s_reg.st == srcp_pkg::SRCP_FLG) s_next.flg = b;
          if (s_reg.st == srcp_pkg::SRCP_ADR) s_next.adr = b;
          if (s_reg.st == srcp_pkg::SRCP_LEN) s_next.len = b;
        end
      end
      srcp_pkg::SRCP_CNT: begin
        if (s_reg.rx_vld) begin
          s_next.cnt     = b;
          s_next.sum     = s_reg.sum ^ b;
          s_next.long_pk = (s_reg.id == 8'h00) && (s_reg.flg == 8'h00);
          s_next.pos     = 8'h00;
          s_next.blk     = 8'h00;
          s_next.nbuf    = 8'h00;
          s_next.match   = 1'b0;
          s_next.bm      = 1'b0;
          s_next.st      = (b == 8'h00 || s_reg.len == 8'h00) ?
                           srcp_pkg::SRCP_SUM : srcp_pkg::SRCP_DAT;
        end
      end
      srcp_pkg::SRCP_DAT: begin
        if (s_reg.rx_vld) begin
          s_next.sum = s_reg.sum ^ b;
          if (s_reg.long_pk && s_reg.pos == 8'h00) begin
            s_next.bm = (b == own_id);
            if (b == own_id) s_next.match = 1'b1;
          end else if ((!s_reg.long_pk || s_reg.bm) && s_reg.nbuf < 8'(BUF)) begin
            s_next.buf_q[s_reg.nbuf] = b;
            s_next.nbuf              = s_reg.nbuf + 8'h01;
          end
          if (s_reg.pos == s_reg.len - 8'h01) begin
            s_next.pos = 8'h00;
            s_next.blk = s_reg.blk + 8'h01;
            if (s_reg.blk == s_reg.cnt - 8'h01) s_next.st = srcp_pkg::SRCP_SUM;
          end else begin
            s_next.pos = s_reg.pos + 8'h01;
          end
        end
      end
      srcp_pkg::SRCP_SUM: begin
        if (s_reg.rx_vld) begin
          s_next.st = (b == s_reg.sum) ? srcp_pkg::SRCP_EXEC : srcp_pkg::SRCP_IDLE;
        end
      end
      srcp_pkg::SRCP_EXEC: begin
        addressed = s_reg.long_pk ? s_reg.match :
                    (s_reg.id == own_id || s_reg.id == `SRCP_BCAST);
        cmd       = !s_reg.long_pk && s_reg.adr == `SRCP_CMD_ADR && s_reg.cnt == 8'h00;
        s_next.st = srcp_pkg::SRCP_IDLE;
        if (addressed && (s_reg.long_pk || s_reg.cnt == 8'h01)) begin
          for (int j = `SRCP_NV_LO; j < `SRCP_MAP_SIZE; j++) begin
            off = 8'(j) - s_reg.adr;
            if (8'(j) >= s_reg.adr && off < s_reg.nbuf && j != `SRCP_RO_LO
                && j != `SRCP_RO_HI) begin
              s_next.mem[j] = s_reg.buf_q[off];
            end
          end
        end
        if (addressed && cmd && s_reg.flg == `SRCP_FLG_COMMIT && s_reg.len == 8'h00) begin
          s_next.nvm    = s_reg.mem[29:4];
          s_next.commit = 1'b1;
        end
        if (addressed && cmd && s_reg.flg == `SRCP_FLG_INIT && s_reg.len == `SRCP_INIT_LEN) begin
          s_next.mem[29:4] = `SRCP_DEFAULTS;
        end
        if (addressed && cmd && s_reg.flg == `SRCP_FLG_REBOOT && s_reg.len == 8'h00) begin
          s_next.mem[29:4]  = s_reg.nvm;
          s_next.mem[59:30] = '0;
          s_next.reboot     = 1'b1;
        end else if (addressed && !s_reg.long_pk && s_reg.id != `SRCP_BCAST) begin
          s_next.ack = 1'b0;
          s_next.st  = srcp_pkg::SRCP_DELAY;
          case (s_reg.flg[3:0])
            4'h1: s_next.ack = 1'b1;
            4'h3: begin s_next.r_adr = 8'd0;  s_next.r_len = 8'd30; end
            4'h5: begin s_next.r_adr = 8'd30; s_next.r_len = 8'd30; end
            4'h7: begin s_next.r_adr = 8'd20; s_next.r_len = 8'd10; end
            4'h9: begin s_next.r_adr = 8'd42; s_next.r_len = 8'd18; end
            4'hb: begin s_next.r_adr = 8'd30; s_next.r_len = 8'd12; end
            4'hf: begin s_next.r_adr = s_reg.adr; s_next.r_len = s_reg.len; end
            default: s_next.st = srcp_pkg::SRCP_IDLE;
          endcase
          s_next.ms_cnt  = 16'h0000;
          s_next.ms_left = s_reg.mem[`SRCP_DLY_IDX];
        end
      end
      srcp_pkg::SRCP_DELAY: begin
        if (s_reg.ms_left == 8'h00) begin
          s_next.st      = srcp_pkg::SRCP_TX;
          s_next.tx_en   = 1'b1;
          s_next.tx_k    = 9'h000;
          s_next.tx_busy = 1'b0;
          s_next.tx_sum  = 8'h00;
        end else if (s_reg.ms_cnt == 16'(MS_CYCLES - 1)) begin
          s_next.ms_cnt  = 16'h0000;
          s_next.ms_left = s_reg.ms_left - 8'h01;
        end else begin
          s_next.ms_cnt = s_reg.ms_cnt + 16'h0001;
        end
      end
      srcp_pkg::SRCP_TX: begin
        if (!s_reg.tx_busy) begin
          s_next.tx_sh   = {1'b1, cur_byte, 1'b0};
          s_next.tx      = 1'b0;
          s_next.tx_busy = 1'b1;
          s_next.tx_bit  = 4'h0;
          s_next.tx_cnt  = div - 16'h0001;
          if (s_reg.tx_k >= 9'h002 && s_reg.tx_k != tx_last) begin
            s_next.tx_sum = s_reg.tx_sum ^ cur_byte;
          end
        end else if (s_reg.tx_cnt != 16'h0000) begin
          s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
        end else if (s_reg.tx_bit == 4'h9) begin
          s_next.tx_busy = 1'b0;
          s_next.tx      = 1'b1;
          s_next.tx_k    = s_reg.tx_k + 9'h001;
          if (s_reg.tx_k == tx_last) begin
            s_next.st    = srcp_pkg::SRCP_IDLE;
            s_next.tx_en = 1'b0;
          end
        end else begin
          s_next.tx_sh  = {1'b1, s_reg.tx_sh[9:1]};
          s_next.tx     = s_reg.tx_sh[1];
          s_next.tx_bit = s_reg.tx_bit + 4'h1;
          s_next.tx_cnt = div - 16'h0001;
        end
      end
      default: s_next.st = srcp_pkg::SRCP_IDLE;
    endcase
    s_next.mem[3:0] = {8'h00, FW_VER, MODEL_H, MODEL_L};
  end

  // State register, flash copy only reset at power-on
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_reg           <= '0;
      s_reg.st        <= srcp_pkg::SRCP_IDLE;
      s_reg.tx        <= 1'b1;
      s_reg.mem[3:0]  <= {8'h00, FW_VER, MODEL_H, MODEL_L};
      s_reg.mem[29:4] <= `SRCP_DEFAULTS;
      s_reg.nvm       <= `SRCP_DEFAULTS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_tx     = s_reg.tx;
  assign o_tx_en  = s_reg.tx_en;
  assign o_rdata  = s_reg.rdata;
  assign o_reboot = s_reg.reboot;
  assign o_commit = s_reg.commit;

  // Checks on the driven behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_drv_off_listen: assert property (s_reg.st != srcp_pkg::SRCP_TX |-> !o_tx_en)
    else $error("driver on outside reply");
  a_hdr_start: assert property (s_reg.st == srcp_pkg::SRCP_IDLE && s_reg.rx_vld
      && s_reg.rx_byte != `SRCP_HDR0 |=> s_reg.st == srcp_pkg::SRCP_IDLE)
    else $error("packet began without header");
  a_sum_reject: assert property (s_reg.st == srcp_pkg::SRCP_SUM && s_reg.rx_vld
      && s_reg.rx_byte != s_reg.sum |=> s_reg.st == srcp_pkg::SRCP_IDLE)
    else $error("bad sum accepted");
  a_sum_accept: assert property (s_reg.st == srcp_pkg::SRCP_SUM && s_reg.rx_vld
      && s_reg.rx_byte == s_reg.sum |=> s_reg.st == srcp_pkg::SRCP_EXEC)
    else $error("good sum refused");
  a_commit_copy: assert property (o_commit |-> s_reg.nvm == $past(s_reg.mem[29:4]))
    else $error("flash copy differs");
  a_reboot_load: assert property (o_reboot |-> s_reg.mem[29:4] == s_reg.nvm
      && s_reg.st == srcp_pkg::SRCP_IDLE)
    else $error("reboot did not reload");
  a_init_id: assert property (s_reg.st == srcp_pkg::SRCP_EXEC && !s_reg.long_pk
      && s_reg.id == `SRCP_BCAST && s_reg.cnt == 8'h00 && s_reg.adr == `SRCP_CMD_ADR
      && s_reg.flg == `SRCP_FLG_INIT && s_reg.len == `SRCP_INIT_LEN
      |=> s_reg.mem[`SRCP_ID_IDX] == `SRCP_DEF_ID)
    else $error("id not one after restore");
  a_ack_byte: assert property (s_reg.st == srcp_pkg::SRCP_TX && s_reg.ack
      |-> cur_byte == `SRCP_ACK && tx_last == 9'h000)
    else $error("ack reply not single 07");
  a_delay_quiet: assert property (s_reg.st == srcp_pkg::SRCP_DELAY
      && s_reg.ms_left != 8'h00 |=> s_reg.st == srcp_pkg::SRCP_DELAY && !o_tx_en)
    else $error("reply before delay");
  a_reply_hdr: assert property ($rose(o_tx_en) && !s_reg.ack
      |-> cur_byte == `SRCP_RHDR0 ##1 !o_tx)
    else $error("reply header wrong");

  c_ack_sent: cover property (s_reg.st == srcp_pkg::SRCP_TX && s_reg.ack && !o_tx);
  c_read_reply: cover property (s_reg.st == srcp_pkg::SRCP_TX && !s_reg.ack
      && s_reg.tx_k == 9'h007);
  c_long_match: cover property (s_reg.st == srcp_pkg::SRCP_EXEC && s_reg.long_pk && s_reg.match);
  c_commit: cover property (o_commit);
endmodule // srcp_parser

// File: verif/srcp_host_model.sv
/*
  Host controller model on the half-duplex RS485 line: sends framed command
  packets on the device's receive line and collects reply bytes.
  Assumes the device bit time equals BIT cycles of i_clock.
*/
`timescale 1ns/1ps
module srcp_host_model #(
  parameter int BIT = 21
) (
  input  wire logic i_clock,
  input  wire logic i_tx,
  input  wire logic i_tx_en,
  output logic      o_rx
);
  logic [7:0] rx_q[$];
  initial o_rx = 1'b1;
  // One 8N1 frame, LSB first, line idles high
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clock);
      o_rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT - 1) @(posedge i_clock);
    end
  endtask
  // Header, body, then XOR of the body; bad flips the sum
  task automatic send_pkt(input logic [7:0] body[$], input bit bad);
    logic [7:0] sum;
    sum = 8'h00;
    send_byte(8'hfa);
    send_byte(8'haf);
    foreach (body[i]) begin
      sum = sum ^ body[i];
      send_byte(body[i]);
    end
    send_byte(bad ? ~sum : sum);
  endtask
  // Reply receiver, sampled mid-bit while the driver is on
  initial begin
    logic [7:0] b;
    forever begin
      @(posedge i_clock);
      if (i_tx_en === 1'b1 && i_tx === 1'b0) begin
        repeat (BIT / 2) @(posedge i_clock);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge i_clock);
          b[i] = i_tx;
        end
        repeat (BIT) @(posedge i_clock);
        rx_q.push_back(b);
      end
    end
  end
endmodule  // srcp_host_model

// File: verif/testbench.sv
/*
  Self-checking bench of the command parser: register port, packets from
  the host model, replies, commands. Runs the link at 460800 bit/s.
*/
`timescale 1ns/1ps
`include "srcp_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic       i_clock, i_sys_rst, i_rx, i_wr, i_rd, tl, ta, ff;
  logic [5:0] i_addr;
  logic [7:0] i_wdata, o_rdata, st;
  logic [2:0] r3;
  logic       o_tx, o_tx_en, o_reboot, o_commit;
  int         fails, checks_done, cycles, commits, reboots, seed;
  int         mem[64];
  int         flash[64];
  srcp_parser #(.MS_CYCLES(10)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_rx(i_rx),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_temp_limit(tl),
    .i_temp_alarm(ta), .i_flash_fail(ff), .o_tx(o_tx), .o_tx_en(o_tx_en), .o_rdata(o_rdata),
    .o_reboot(o_reboot), .o_commit(o_commit));
  srcp_host_model #(.BIT(21)) host (.i_clock(i_clock), .i_tx(o_tx), .i_tx_en(o_tx_en),
    .o_rx(i_rx));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // Pulse counters and hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (o_commit === 1'b1) commits++;
    if (o_reboot === 1'b1) reboots++;
    if (cycles == 90000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input int a, input int d);
    @(posedge i_clock);
    i_wr <= 1'b1; i_addr <= 6'(a); i_wdata <= 8'(d);
    @(posedge i_clock);
    i_wr <= 1'b0;
    if (!(a < 4 || a == 14 || a == 15 || a >= 60)) mem[a] = d;
  endtask
  task automatic rd_chk(input int a);
    @(posedge i_clock);
    i_rd <= 1'b1; i_addr <= 6'(a);
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, 8'(mem[a]))
  endtask
  // Host waits for the whole reply before anything else
  task automatic wait_reply(input int n);
    for (int i = 0; i < 20000 && host.rx_q.size() < n; i++) @(posedge i_clock);
    repeat (60) @(posedge i_clock);
    `CHK(8'(host.rx_q.size()), 8'(n))
    `CHK(o_tx_en, 1'b0)
  endtask
  task automatic chk_reply(input int adr, input int len);
    logic [7:0] s;
    wait_reply(len + 8);
    `CHK(host.rx_q.pop_front(), 8'hfd)
    `CHK(host.rx_q.pop_front(), 8'hdf)
    s = 8'(mem[4]) ^ st ^ 8'(adr) ^ 8'(len) ^ 8'h01;
    `CHK(host.rx_q.pop_front(), 8'(mem[4]))
    `CHK(host.rx_q.pop_front(), st)
    `CHK(host.rx_q.pop_front(), 8'(adr))
    `CHK(host.rx_q.pop_front(), 8'(len))
    `CHK(host.rx_q.pop_front(), 8'h01)
    for (int i = 0; i < len; i++) begin
      s = s ^ 8'(mem[adr+i]);
      `CHK(host.rx_q.pop_front(), 8'(mem[adr+i]))
    end
    `CHK(host.rx_q.pop_front(), s)
  endtask
  initial begin
    seed = 67;
    i_sys_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 6'h00; i_wdata = 8'h00;
    tl = 1'b0; ta = 1'b0; ff = 1'b0;
    mem = '{default: 0};
    mem[0] = 8'h5a; mem[1] = 8'ha5; mem[2] = 8'h01;
    for (int i = 4; i < 30; i++) mem[i] = `SRCP_DEFAULTS >> (8 * (i - 4)) & 8'hff;
    flash = mem;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    foreach (mem[i]) if (i < 30 || i == 60) rd_chk(i);
    // Read-only and unmapped writes are ignored; baud goes to 460800
    wr(3, $random(seed)); wr(14, $random(seed)); wr(61, $random(seed));
    wr(5, $random(seed)); wr(6, 8'h0a);
    rd_chk(3); rd_chk(14); rd_chk(5); rd_chk(61);
    host.send_pkt('{8'h01, 8'h01, 8'h00, 8'h00, 8'h00}, 1'b0);
    wait_reply(1);
    `CHK(host.rx_q.pop_front(), 8'h07)
    // Broadcast ID write takes effect at once, no reply
    host.send_pkt('{8'hff, 8'h00, 8'h04, 8'h01, 8'h01, 8'h05}, 1'b0);
    mem[4] = 5;
    wait_reply(0);
    rd_chk(4);
    host.send_pkt('{8'h05, 8'h00, 8'h05, 8'h01, 8'h01, 8'h33}, 1'b1);
    wait_reply(0);
    host.send_pkt('{8'h09, 8'h01, 8'h05, 8'h01, 8'h01, 8'h33}, 1'b0);
    wait_reply(0);
    rd_chk(5);
    // Status bits follow the thermal and flash inputs; free-range read
    r3 = 3'($random(seed));
    {tl, ta, ff} <= r3;
    st = {r3[2], 1'b0, r3[1], 1'b0, r3[0], 3'b000};
    host.send_pkt('{8'h05, 8'h0f, 8'h04, 8'h03, 8'h00}, 1'b0);
    chk_reply(4, 3);
    host.send_pkt('{8'h00, 8'h00, 8'h18, 8'h02, 8'h02, 8'h07, 8'haa, 8'h05, 8'hbb}, 1'b0);
    mem[24] = 8'hbb;
    wait_reply(0);
    rd_chk(24);
    host.send_pkt('{8'h05, 8'h07, 8'h00, 8'h00, 8'h01}, 1'b0);
    chk_reply(20, 10);
    host.send_pkt('{8'h05, 8'h10, 8'hff, 8'hff, 8'h00}, 1'b0);
    for (int i = 4; i < 30; i++) mem[i] = flash[i];
    repeat (30) @(posedge i_clock);
    wr(6, 8'h0a);
    rd_chk(4);
    rd_chk(24);
    host.send_pkt('{8'h01, 8'h40, 8'hff, 8'h00, 8'h00}, 1'b0);
    repeat (30) @(posedge i_clock);
    `CHK(8'(commits), 8'h01)
    flash = mem;
    // Host keeps off the line for one scaled second after a commit
    repeat (10000) @(posedge i_clock);
    wr(5, 8'h44); wr(30, $random(seed));
    host.send_pkt('{8'h01, 8'h20, 8'hff, 8'h00, 8'h00}, 1'b0);
    repeat (30) @(posedge i_clock);
    `CHK(8'(reboots), 8'h01)
    for (int i = 4; i < 60; i++) mem[i] = (i < 30) ? flash[i] : 0;
    rd_chk(5); rd_chk(6); rd_chk(30);
    tally_and_finish();
  end
endmodule  // testbench
